// [hdl/fbc_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
module fbc_ctrl
   import fbc_pkg::*;
#(
   parameter int ACC_CYC = FBC_ACC_CYC,
   parameter int WE_CYC = FBC_WE_CYC,
   parameter int RP_CYC = FBC_RP_CYC,
   parameter int RH_CYC = FBC_RH_CYC,
   parameter int READY_CYC = FBC_READY_CYC
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // software port
   input wire logic [3:0] sw_addr,
   input wire logic [31:0] sw_wdata,
   input wire logic sw_wr,
   input wire logic sw_rd,
   output logic [31:0] sw_rdata,
   // flash control pins
   output fbc_ctl_s ctl,
   output logic [FBC_AW-1:0] flash_addr,
   // flash data pins, oe low drives
   input wire logic [FBC_DW-1:0] dq_in,
   output logic [FBC_DW-1:0] dq_out,
   output logic dq_oe_n,
   // busy pin from the device
   input wire logic op_done_pin
);
   fbc_state_e state_reg;
   logic [FBC_CW-1:0] cnt_reg;
   logic [FBC_AW-1:0] addr_reg;
   logic [FBC_DW-1:0] wdata_reg;
   logic [FBC_DW-1:0] rdata_reg;
   logic [1:0] cfg_reg;
   logic [2:0] done_sync_reg;
   logic ready_reg;
   logic interrupted_reg;
   fbc_req_s req;

   assign req = '{addr: sw_addr, wdata: sw_wdata, wr: sw_wr, rd: sw_rd};

   ////////////////////////////////////////////////////////////////////
   // busy pin: three stages, change accepted when last two agree
   always_ff @(posedge clk) begin
      if (rst) begin
         done_sync_reg <= 3'h7;
      end else begin
         done_sync_reg <= {done_sync_reg[1:0], op_done_pin};
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ready_reg <= 1'b1;
      end else if (done_sync_reg[2] == done_sync_reg[1]) begin
         ready_reg <= done_sync_reg[2];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // configuration; boost high voltage only while a write is underway
   always_ff @(posedge clk) begin
      if (rst) begin
         cfg_reg <= 2'h1;
      end else if (req.wr && req.addr == FBC_REG_CFG) begin
         cfg_reg <= req.wdata[1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         addr_reg <= '0;
         wdata_reg <= '0;
      end else if (req.wr && req.addr == FBC_REG_ADDR) begin
         addr_reg <= req.wdata[FBC_AW-1:0];
      end else if (req.wr && req.addr == FBC_REG_WDATA) begin
         wdata_reg <= req.wdata[FBC_DW-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // bus cycle sequencer; one flash cycle per command
   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= FBC_RST;
         cnt_reg <= FBC_CW'(RP_CYC);
         interrupted_reg <= 1'b0;
      end else begin
         case (state_reg)
            FBC_IDLE: begin
               if (req.wr && req.addr == FBC_REG_CMD) begin
                  if (req.wdata[1:0] == FBC_CMD_READ) begin
                     state_reg <= FBC_RD;
                     cnt_reg <= FBC_CW'(ACC_CYC);
                  end else if (req.wdata[1:0] == FBC_CMD_WRITE) begin
                     state_reg <= FBC_WR;
                     // extra cycle keeps select and data past the strobe's rise
                     cnt_reg <= FBC_CW'(WE_CYC) + FBC_CW'(1);
                  end else if (req.wdata[1:0] == FBC_CMD_RESET) begin
                     state_reg <= FBC_RST;
                     cnt_reg <= FBC_CW'(RP_CYC);
                     interrupted_reg <= !ready_reg;
                  end
               end
            end
            FBC_RD, FBC_WR: begin
               if (cnt_reg <= FBC_CW'(1)) begin
                  state_reg <= FBC_IDLE;
               end else begin
                  cnt_reg <= cnt_reg - FBC_CW'(1);
               end
            end
            FBC_RST: begin
               if (cnt_reg <= FBC_CW'(1)) begin
                  state_reg <= FBC_REC;
                  cnt_reg <= FBC_CW'(RH_CYC);
               end else begin
                  cnt_reg <= cnt_reg - FBC_CW'(1);
               end
            end
            default: begin
               // wait out reset recovery delay and busy low
               if (cnt_reg <= FBC_CW'(1) && ready_reg) begin
                  state_reg <= FBC_IDLE;
               end else if (cnt_reg > FBC_CW'(1)) begin
                  cnt_reg <= cnt_reg - FBC_CW'(1);
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // pins, all registered
   always_ff @(posedge clk) begin
      if (rst) begin
         ctl <= '{sel_n: 1'b1, gate_n: 1'b1, wstb_n: 1'b1, word_sel: 1'b1,
                  reset_n: 1'b0, boost_hv: 1'b0, boost_high: 1'b1};
         flash_addr <= '0;
         dq_out <= '0;
         dq_oe_n <= 1'b1;
      end else begin
         ctl.word_sel <= cfg_reg[FBC_CFG_WORD];
         ctl.boost_high <= 1'b1;
         ctl.reset_n <= (state_reg != FBC_RST);
         ctl.sel_n <= !(state_reg == FBC_RD || state_reg == FBC_WR);
         ctl.gate_n <= (state_reg != FBC_RD);
         ctl.wstb_n <= !(state_reg == FBC_WR && cnt_reg > FBC_CW'(1));
         ctl.boost_hv <= cfg_reg[FBC_CFG_BOOST] && state_reg == FBC_WR;
         // byte mode: top lane carries the low address bit
         flash_addr <= addr_reg;
         dq_out <= cfg_reg[FBC_CFG_WORD] ? wdata_reg : {addr_reg[0], 7'h00, wdata_reg[7:0]};
         dq_oe_n <= !(state_reg == FBC_WR || !cfg_reg[FBC_CFG_WORD]);
      end
   end

   // sample while the gate is still low, pins then low for ACC_CYC cycles
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_reg <= '0;
      end else if (state_reg != FBC_RD && !ctl.gate_n) begin
         rdata_reg <= cfg_reg[FBC_CFG_WORD] ? dq_in : {8'h00, dq_in[7:0]};
      end
   end

   ////////////////////////////////////////////////////////////////////
   // read port, data one cycle after strobe
   always_ff @(posedge clk) begin
      if (rst) begin
         sw_rdata <= '0;
      end else if (req.rd) begin
         if (req.addr == FBC_REG_ADDR) begin
            sw_rdata <= 32'(addr_reg);
         end else if (req.addr == FBC_REG_WDATA) begin
            sw_rdata <= 32'(wdata_reg);
         end else if (req.addr == FBC_REG_STAT) begin
            sw_rdata <= {27'h0, interrupted_reg, cfg_reg[FBC_CFG_BOOST],
                         cfg_reg[FBC_CFG_WORD], ready_reg, state_reg != FBC_IDLE};
         end else if (req.addr == FBC_REG_RDATA) begin
            sw_rdata <= 32'(rdata_reg);
         end else if (req.addr == FBC_REG_CFG) begin
            sw_rdata <= 32'(cfg_reg);
         end else begin
            sw_rdata <= 32'h00000000;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   sequence pins_read_s;
      !ctl.sel_n && !ctl.gate_n && ctl.wstb_n;
   endsequence

   sequence pins_write_s;
      !ctl.sel_n && ctl.gate_n && !ctl.wstb_n;
   endsequence

   write_gate_a: assert property (@(posedge clk) disable iff (rst)
      !ctl.wstb_n |-> pins_write_s) else $error("write without gate high");
   write_hold_a: assert property (@(posedge clk) disable iff (rst)
      $rose(ctl.wstb_n) |-> !ctl.sel_n ##1 ctl.sel_n) else $error("select dropped with strobe");
   boost_only_a: assert property (@(posedge clk) disable iff (rst)
      ctl.boost_hv |-> !ctl.sel_n && ctl.gate_n) else $error("boost outside write");
   reset_pulse_a: assert property (@(posedge clk) disable iff (rst)
      $fell(ctl.reset_n) |=> !ctl.reset_n [*2]) else $error("reset pulse short");
   reset_quiet_a: assert property (@(posedge clk) disable iff (rst)
      !ctl.reset_n |-> ctl.sel_n && ctl.wstb_n) else $error("access during reset pulse");
   read_gate_a: assert property (@(posedge clk) disable iff (rst)
      $fell(ctl.gate_n) |-> pins_read_s) else $error("read gate bad");
   // three cycles of 40 ns cover the select access time at this clock
   read_access_a: assert property (@(posedge clk) disable iff (rst)
      $fell(ctl.gate_n) |-> pins_read_s [*3]) else $error("read released early");
endmodule
`default_nettype wire

// [hdl/fbc_pkg.sv]
package fbc_pkg;
   // bus widths of the flash pin side
   localparam int FBC_AW = 21;
   localparam int FBC_DW = 16;
   // timing figures in ns
   localparam int FBC_CLK_NS = 40;
   localparam int FBC_ACC_NS = 90;
   localparam int FBC_SLEEP_EXTRA_NS = 30;
   localparam int FBC_WE_NS = 35;
   localparam int FBC_RP_NS = 500;
   localparam int FBC_RH_NS = 50;
   localparam int FBC_READY_NS = 20000;
   // cycle counts: least times round up
   localparam int FBC_ACC_CYC = (FBC_ACC_NS + FBC_CLK_NS - 1) / FBC_CLK_NS;
   localparam int FBC_WE_CYC = (FBC_WE_NS + FBC_CLK_NS - 1) / FBC_CLK_NS;
   localparam int FBC_RP_CYC = (FBC_RP_NS + FBC_CLK_NS - 1) / FBC_CLK_NS;
   localparam int FBC_RH_CYC = (FBC_RH_NS + FBC_CLK_NS - 1) / FBC_CLK_NS;
   localparam int FBC_READY_CYC = (FBC_READY_NS + FBC_CLK_NS - 1) / FBC_CLK_NS;
   localparam int FBC_SLEEP_CYC =
      (FBC_ACC_NS + FBC_SLEEP_EXTRA_NS + FBC_CLK_NS - 1) / FBC_CLK_NS;
   localparam int FBC_CW = 16;
   // register map of the controller
   localparam logic [3:0] FBC_REG_ADDR = 4'h0;
   localparam logic [3:0] FBC_REG_WDATA = 4'h1;
   localparam logic [3:0] FBC_REG_CMD = 4'h2;
   localparam logic [3:0] FBC_REG_STAT = 4'h3;
   localparam logic [3:0] FBC_REG_RDATA = 4'h4;
   localparam logic [3:0] FBC_REG_CFG = 4'h5;
   // command codes written to FBC_REG_CMD
   localparam logic [1:0] FBC_CMD_READ = 2'h1;
   localparam logic [1:0] FBC_CMD_WRITE = 2'h2;
   localparam logic [1:0] FBC_CMD_RESET = 2'h3;
   // cfg bits
   localparam int FBC_CFG_WORD = 0;
   localparam int FBC_CFG_BOOST = 1;
   // stat bits
   localparam int FBC_ST_BUSY = 0;
   localparam int FBC_ST_READY = 1;
   localparam int FBC_ST_WORD = 2;
   localparam int FBC_ST_BOOST = 3;

   typedef enum logic [2:0] {
      FBC_IDLE = 3'b000,
      FBC_RD = 3'b001,
      FBC_WR = 3'b010,
      FBC_RST = 3'b011,
      FBC_REC = 3'b100
   } fbc_state_e;

   typedef struct packed {
      logic [3:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } fbc_req_s;

   typedef struct packed {
      logic sel_n;
      logic gate_n;
      logic wstb_n;
      logic word_sel;
      logic reset_n;
      logic boost_hv;
      logic boost_high;
   } fbc_ctl_s;
endpackage

// [tb/fbc_flash_model.sv]
`timescale 1ns/1ps
`default_nettype none
module fbc_flash_model
   import fbc_pkg::*;
#(
   parameter int PROG_NS = 1000,
   parameter int READY_NS = 400
) (
   // pins from the controller
   input wire fbc_ctl_s ctl,
   input wire logic [FBC_AW-1:0] flash_addr,
   input wire logic [FBC_DW-1:0] dq_out,
   input wire logic dq_oe_n,
   // device side
   output var logic [FBC_DW-1:0] dq_in,
   output var logic op_done_pin,
   output var logic [FBC_AW-1:0] wr_addr,
   output var logic [FBC_DW-1:0] wr_data,
   output var int viol
);
   realtime busy_end = 0;
   realtime rst_fall = 0;
   realtime rst_rise = 0;
   initial begin
      dq_in = 16'h0000;
      viol = 0;
   end
   ////////////////////////////////////////////////////////////////
   // lanes flip first, so a too-early sample never looks valid
   always @(flash_addr or ctl) begin
      dq_in = ~dq_in;
      dq_in <= #(FBC_ACC_NS) (!ctl.sel_n && !ctl.gate_n && ctl.reset_n) ?
         (flash_addr[15:0] ^ {11'h0, flash_addr[20:16]} ^ 16'h5A3C) : ~dq_in;
   end
   always @(posedge ctl.wstb_n) if (!ctl.sel_n && ctl.reset_n) begin
      wr_addr = flash_addr;
      wr_data = dq_out;
      busy_end = $realtime + (ctl.boost_hv ? PROG_NS / 4 : PROG_NS);
      if (ctl.gate_n !== 1'b1) viol++;
      if (ctl.boost_hv !== 1'b1 && ctl.boost_high !== 1'b1) viol++;
   end
   always @(ctl.boost_hv or ctl.gate_n) if (ctl.boost_hv && !ctl.gate_n) viol++;
   always @(negedge ctl.gate_n) if (!dq_oe_n || $realtime - rst_rise < FBC_RH_NS) viol++;
   always @(negedge ctl.reset_n) begin
      rst_fall = $realtime;
      if ($realtime < busy_end) busy_end = 1.0e9;
   end
   always @(posedge ctl.reset_n) begin
      rst_rise = $realtime;
      if ($realtime - rst_fall < FBC_RP_NS) viol++;
      if (busy_end > 1.0e8) busy_end = $realtime + READY_NS;
   end
   always #10 op_done_pin = ($realtime >= busy_end);
endmodule
`default_nettype wire

// [tb/flash_bus_operation_control_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
   $display("FAIL %s exp %h got %h", nm, e, g); end end
module flash_bus_operation_control_tb_top;
   import fbc_pkg::*;
   logic clk = 0;
   logic rst = 1;
   logic [3:0] sw_addr = 4'h0;
   logic [31:0] sw_wdata = 32'h0, sw_rdata, a, d, e, m;
   logic sw_wr = 0, sw_rd = 0, rd_q = 0, dq_oe_n, op_done_pin, b;
   fbc_ctl_s ctl;
   logic [FBC_AW-1:0] flash_addr, wr_addr;
   logic [FBC_DW-1:0] dq_in, dq_out, wr_data, wexp;
   int viol, miscompares = 0, comparisons = 0, cycles = 0;
   logic [31:0] exp_q[$], msk_q[$];
   fbc_ctrl #(.READY_CYC(50)) u_fbc_ctrl(.clk(clk), .rst(rst), .sw_addr(sw_addr),
      .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .ctl(ctl),
      .flash_addr(flash_addr), .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
      .op_done_pin(op_done_pin));
   fbc_flash_model u_fbc_flash_model(.ctl(ctl), .flash_addr(flash_addr), .dq_out(dq_out),
      .dq_oe_n(dq_oe_n), .dq_in(dq_in), .op_done_pin(op_done_pin), .wr_addr(wr_addr),
      .wr_data(wr_data), .viol(viol));
   initial forever #20 clk = ~clk;
   ////////////////////////////////////////////////////////////////
   task automatic tally_and_finish();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic reg_wr(input logic [3:0] ad, input logic [31:0] v);
      @(posedge clk);
      sw_wr <= 1'b1;
      sw_addr <= ad;
      sw_wdata <= v;
      @(posedge clk);
      sw_wr <= 1'b0;
   endtask
   task automatic reg_rd(input logic [3:0] ad, input logic [31:0] ev, input logic [31:0] mv);
      @(posedge clk);
      sw_rd <= 1'b1;
      sw_addr <= ad;
      exp_q.push_back(ev);
      msk_q.push_back(mv);
      @(posedge clk);
      sw_rd <= 1'b0;
   endtask
   // polls status; a stuck busy bit counts as a miscompare
   task automatic wait_idle();
      for (int i = 0; i < 300; i++) begin
         reg_rd(FBC_REG_STAT, 32'h0, 32'h0);
         @(posedge clk);
         if (sw_rdata[FBC_ST_BUSY] === 1'b0) return;
      end
      miscompares++;
   endtask
   task automatic flash_rd();
      a = $urandom & 32'h001FFFFF;
      reg_wr(FBC_REG_ADDR, a);
      reg_wr(FBC_REG_CMD, {30'h0, FBC_CMD_READ});
      wait_idle();
      reg_rd(FBC_REG_RDATA, {16'h0, a[15:0] ^ {11'h0, a[20:16]} ^ 16'h5A3C}, 32'h0000FFFF);
   endtask
   ////////////////////////////////////////////////////////////////
   always @(posedge clk) begin
      rd_q <= sw_rd;
      cycles <= cycles + 1;
      if (rd_q) begin
         e = exp_q.pop_front();
         m = msk_q.pop_front();
         `CHK("sw_rdata", e & m, sw_rdata & m)
      end
      if (cycles == 20000) begin
         miscompares++;
         tally_and_finish();
      end
   end
   initial begin
      void'($urandom(88));
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      wait_idle();
      `CHK("word_sel", 1'b1, ctl.word_sel)
      reg_rd(FBC_REG_CFG, 32'h1, 32'h3);
      reg_rd(4'hF, 32'h0, 32'hFFFFFFFF);
      repeat (6) flash_rd();
      // boosted word, plain byte, then plain word so the device is still busy
      for (int i = 0; i < 3; i++) begin
         a = $urandom & 32'h001FFFFF;
         d = $urandom & 32'h0000FFFF;
         reg_wr(FBC_REG_CFG, {30'h0, i == 0, i != 1});
         reg_wr(FBC_REG_ADDR, a);
         reg_wr(FBC_REG_WDATA, d);
         reg_wr(FBC_REG_CMD, {30'h0, FBC_CMD_WRITE});
         wait_idle();
         // byte mode: top lane carries the low address bit
         wexp = (i == 1) ? {a[0], 7'h00, d[7:0]} : d[15:0];
         `CHK("word_sel", i != 1, ctl.word_sel)
         `CHK("wr_addr", a[20:0], wr_addr)
         `CHK("wr_data", wexp, wr_data)
      end
      b = !op_done_pin;
      reg_wr(FBC_REG_CMD, {30'h0, FBC_CMD_RESET});
      wait_idle();
      `CHK("op_done_pin", 1'b1, op_done_pin)
      reg_rd(FBC_REG_STAT, {27'h0, b, 4'h0}, 32'h10);
      flash_rd();
      repeat (3) @(posedge clk);
      `CHK("viol", 0, viol)
      tally_and_finish();
   end
endmodule
`default_nettype wire
